//--- common/sdr_pkg.sv
// Constants, field layout and state type for the start-up reset sequencer
package sdr_pkg;

  // System clock and pulse-width filters
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int EXT_PULSE_NS      = 50;
  localparam int EXT_PULSE_CYC     =
    (EXT_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int BOD_FILT_HI_NS    = 7000;
  localparam int BOD_FILT_LO_NS    = 24000;
  localparam int BOD_FILT_HI_CYC   =
    (BOD_FILT_HI_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int BOD_FILT_LO_CYC   =
    (BOD_FILT_LO_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int EXT_FILT_W        = 3;
  localparam int BOD_FILT_W        = 12;

  // Counter widths
  localparam int WDT_CNT_W = 21;
  localparam int CLK_CNT_W = 16;

  // Watchdog oscillator cycle counts
  localparam int WDT_67US = 16;
  localparam int WDT_256  = 256;
  localparam int WDT_1K   = 1024;
  localparam int WDT_4K   = 4096;
  localparam int WDT_16K  = 16384;
  localparam int WDT_1M   = 1048576;

  // System clock cycle counts
  localparam int CK_6        = 6;
  localparam int CK_1K       = 1024;
  localparam int CK_16K      = 16384;
  localparam int CK_32K      = 32768;
  localparam int CK_EXT_RST  = 5;
  localparam int CK_EXT_WAKE = 2;

  // Clock option of the smaller variant
  localparam logic [2:0] OPT_XTAL   = 3'h0;
  localparam logic [2:0] OPT_RESON  = 3'h1;
  localparam logic [2:0] OPT_LOWF   = 3'h2;
  localparam logic [2:0] OPT_EXT_RC = 3'h3;
  localparam logic [2:0] OPT_INT_RC = 3'h4;
  localparam logic [2:0] OPT_EXTCLK = 3'h5;

  // Register byte offsets
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_FUSE     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_WDT_LOAD = 8'h08;
  localparam logic [7:0]  OFF_CLK_LOAD = 8'h0C;

  // Fuse register fields
  localparam int FB_CKSEL   = 0;
  localparam int FB_FAST    = 4;
  localparam int FB_BODLVL  = 5;
  localparam int FB_BOD_EN  = 6;
  localparam int FB_LARGE   = 7;
  localparam int FB_OPT     = 8;
  localparam logic [31:0] FUSE_RESET = 32'h0000_0482;
  localparam logic [31:0] FUSE_MASK  = 32'h0000_07FF;

  // Status register fields
  localparam int SB_CORE_RST = 0;
  localparam int SB_POR      = 1;
  localparam int SB_EXT      = 2;
  localparam int SB_BOD      = 3;
  localparam int SB_WDT      = 4;
  localparam int SB_CLK      = 5;
  localparam int SB_SLEEP    = 6;
  localparam int SB_WAKING   = 7;

  // Program start after reset
  localparam int        PC_W         = 10;
  localparam logic [9:0] RESET_VECTOR = 10'h000;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_WDT,
    ST_CLK,
    ST_RUN,
    ST_SLEEP
  } sdr_state_t;

endpackage

//--- hdl/sdr_down_counter.sv
// Loadable down counter that decrements on a tick and flags zero
`timescale 1ns/1ps
`default_nettype none
module sdr_down_counter
  import sdr_pkg::*;
#(
  parameter int unsigned W = 16
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_load_val,
  input  wire logic         i_tick,
  output logic              o_done
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_load_val;
    end else if (i_tick && (count != '0)) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_done = (count == '0) && !i_load;

endmodule
`default_nettype wire

//--- hdl/sdr_reset_sequencer.sv
// Start-up delay reset sequencer with APB fuse and status registers
//
// What this block does
// [R01] Hold core after power-on until watchdog timeout
// [R02] Fast-startup fuse shortens small-variant delays, except the low-frequency option
// [R03] Small external clock: 4.2ms, or 5/2 clocks
// [R04] Low reset pin extends the power-on reset
// [R05] Clock-select field picks watchdog plus clock delay
// [R06] Crystal codes add 1K/16K; low-frequency 1K/32K
// [R07] RC and external clock codes add 6 clocks
// [R08] Wake from sleep counts clocks only
// [R09] Level fuse: 256/4K or 1K/16K watchdog cycles
// [R10] Level fuse picks counts even without brown-out
// [R11] Clock-select field resets to 0010
// [R12] Supply below threshold resets at once
// [R13] Pin low over 50ns resets the device
// [R14] Pin rising starts delay, then core released
// [R15] Brown-out resets at once, same release delay
// [R16] Level fuse picks brown-out trigger level
// [R17] Brown-out ignores dips under 7us or 24us
// [R18] Prefer ceramic resonator with 1K-cycle codes
// [R19] Any request restarts delay; release needs none
// [R20] Reset clears I/O and restarts at 000
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sdr_reset_sequencer
  import sdr_pkg::*;
#(
  parameter int unsigned WDT_W = WDT_CNT_W,
  parameter int unsigned CLK_W = CLK_CNT_W
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic [31:0]            o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_supply_ok,
  input  wire logic              i_ext_reset_n,
  input  wire logic              i_brownout_low,
  input  wire logic              i_wdog_osc_tick,
  input  wire logic              i_power_down,
  input  wire logic              i_wake,
  output logic                   o_core_reset,
  output logic                   o_core_stall,
  output logic                   o_io_init,
  output logic                   o_fetch_restart,
  output logic [PC_W-1:0]        o_start_addr,
  output logic                   o_brownout_enable,
  output logic                   o_brownout_level_high
);

  // Watchdog-timed part of the start-up delay
  function automatic logic [WDT_W-1:0] wdt_count(input logic [31:0] f);
    logic [3:0] cks;
    logic       fast;
    logic       lvl;
    int         n;
    int         sh;
    int         lg;
    cks  = f[FB_CKSEL +: 4];
    fast = f[FB_FAST];
    lvl  = f[FB_BODLVL];
    sh   = lvl ? WDT_1K : WDT_256; // R09 R10
    lg   = lvl ? WDT_16K : WDT_4K; // R09 R10
    n    = 0;
    if (f[FB_LARGE]) begin
      unique case (cks) // R05
        4'hF, 4'hC, 4'h7, 4'h4, 4'h1: n = 0;
        4'hE, 4'hB, 4'h6, 4'h3, 4'h0: n = sh;
        default:                      n = lg;
      endcase
    end else begin
      unique case (f[FB_OPT +: 3])
        OPT_XTAL, OPT_RESON: n = fast ? WDT_1K : WDT_16K; // R02
        OPT_LOWF:            n = WDT_1M; // R02
        OPT_EXTCLK:          n = fast ? 0 : WDT_1K; // R03
        default:             n = fast ? WDT_67US : WDT_1K; // R02
      endcase
    end
    return WDT_W'(n);
  endfunction

  // System clock counting part of the start-up delay
  function automatic logic [CLK_W-1:0] clk_count(input logic [31:0] f,
                                                 input logic        wake);
    logic [3:0] cks;
    int         n;
    cks = f[FB_CKSEL +: 4];
    n   = 0;
    if (f[FB_LARGE]) begin
      unique case (cks)
        4'hF, 4'hE, 4'hD, 4'h9: n = CK_1K; // R06
        4'hC, 4'hB, 4'hA:       n = CK_16K; // R06
        4'h8:                   n = CK_32K; // R06
        default:                n = CK_6; // R07
      endcase
    end else if ((f[FB_OPT +: 3] == OPT_EXTCLK) && f[FB_FAST]) begin
      n = wake ? CK_EXT_WAKE : CK_EXT_RST; // R03
    end
    return CLK_W'(n);
  endfunction

  // Load value so that the counting phase lasts exactly n cycles
  function automatic logic [CLK_W-1:0] clk_load_of(input logic [CLK_W-1:0] n);
    return (n == '0) ? '0 : n - CLK_W'(1);
  endfunction

  // Fuse register and APB slave
  logic [31:0] fuse;
  logic [31:0] next_fuse;
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [31:0] status;

  // Request filters
  logic [EXT_FILT_W-1:0] ext_cnt;
  logic [EXT_FILT_W-1:0] next_ext_cnt;
  logic [BOD_FILT_W-1:0] bod_cnt;
  logic [BOD_FILT_W-1:0] next_bod_cnt;
  logic [BOD_FILT_W-1:0] bod_lim;
  logic                  por_req;
  logic                  ext_req;
  logic                  bod_req;
  logic                  any_req;

  // Sequencer
  sdr_state_t            state;
  sdr_state_t            next_state;
  logic                  waking;
  logic                  next_waking;
  logic                  next_restart;
  logic                  wdt_load;
  logic                  wdt_done;
  logic                  clk_load;
  logic                  clk_done;
  logic [CLK_W-1:0]      clk_val;
  logic [WDT_W-1:0]      wdt_rst_n;
  logic [CLK_W-1:0]      clk_rst_n;
  logic [CLK_W-1:0]      clk_wake_n;

  assign wdt_rst_n  = wdt_count(fuse);
  assign clk_rst_n  = clk_count(fuse, 1'b0);
  assign clk_wake_n = clk_count(fuse, 1'b1);

  always_comb begin
    status = '0;
    status[SB_CORE_RST] = o_core_reset;
    status[SB_POR]      = por_req;
    status[SB_EXT]      = ext_req;
    status[SB_BOD]      = bod_req;
    status[SB_WDT]      = (state == ST_WDT);
    status[SB_CLK]      = (state == ST_CLK);
    status[SB_SLEEP]    = (state == ST_SLEEP);
    status[SB_WAKING]   = waking;
  end

  always_comb begin
    next_fuse    = fuse;
    next_prdata  = o_prdata;
    next_pslverr = o_pslverr;
    if (i_psel && i_penable && i_pwrite && (i_paddr == OFF_FUSE)) begin
      next_fuse = i_pwdata & FUSE_MASK;
    end
    if (i_psel && !i_penable) begin
      next_pslverr = 1'b0;
      next_prdata  = '0;
      unique case (i_paddr)
        OFF_FUSE: begin
          next_prdata = fuse;
        end
        OFF_STATUS: begin
          next_prdata  = status;
          next_pslverr = i_pwrite;
        end
        OFF_WDT_LOAD: begin
          next_prdata  = 32'(wdt_rst_n);
          next_pslverr = i_pwrite;
        end
        OFF_CLK_LOAD: begin
          next_prdata  = 32'(clk_rst_n);
          next_pslverr = i_pwrite;
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fuse      <= FUSE_RESET; // R11
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else begin
      fuse      <= next_fuse;
      o_prdata  <= next_prdata;
      o_pslverr <= next_pslverr;
    end
  end

  assign o_pready = i_psel && i_penable;

  // Reset requests
  assign bod_lim = fuse[FB_BODLVL] ? BOD_FILT_W'(BOD_FILT_HI_CYC)
                                   : BOD_FILT_W'(BOD_FILT_LO_CYC); // R17

  always_comb begin
    next_ext_cnt = '0;
    next_bod_cnt = '0;
    if (!i_ext_reset_n) begin
      next_ext_cnt = ext_req ? ext_cnt : ext_cnt + EXT_FILT_W'(1); // R13
    end
    if (fuse[FB_BOD_EN] && i_brownout_low) begin
      next_bod_cnt = bod_req ? bod_cnt : bod_cnt + BOD_FILT_W'(1); // R17
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_cnt <= '0;
      bod_cnt <= '0;
    end else begin
      ext_cnt <= next_ext_cnt;
      bod_cnt <= next_bod_cnt;
    end
  end

  assign por_req = !i_supply_ok; // R12
  assign ext_req = (ext_cnt == EXT_FILT_W'(EXT_PULSE_CYC)); // R13 R04
  assign bod_req = fuse[FB_BOD_EN] && (bod_cnt >= bod_lim); // R15
  assign any_req = por_req || ext_req || bod_req; // R19

  // Delay counters
  sdr_down_counter #(
    .W          (WDT_W)
  ) u_wdt_cnt (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_load     (wdt_load),
    .i_load_val (wdt_rst_n),
    .i_tick     ((state == ST_WDT) && i_wdog_osc_tick), // R01
    .o_done     (wdt_done)
  );

  sdr_down_counter #(
    .W          (CLK_W)
  ) u_clk_cnt (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_load     (clk_load),
    .i_load_val (clk_val),
    .i_tick     (state == ST_CLK),
    .o_done     (clk_done)
  );

  always_comb begin
    next_state   = state;
    next_waking  = waking;
    next_restart = 1'b0;
    wdt_load     = 1'b0;
    clk_load     = 1'b0;
    clk_val      = clk_load_of(clk_rst_n);
    unique case (state)
      ST_HOLD: begin
        wdt_load    = 1'b1; // R19
        clk_load    = 1'b1; // R19
        next_waking = 1'b0;
        if (!any_req) begin
          next_state = ST_WDT; // R14 R04
        end
      end
      ST_WDT: begin
        if (any_req) begin
          next_state = ST_HOLD; // R19
        end else if (wdt_done) begin
          if (clk_rst_n == '0) begin
            next_state   = ST_RUN;
            next_restart = 1'b1;
          end else begin
            next_state = ST_CLK; // R05
          end
        end
      end
      ST_CLK: begin
        if (any_req) begin
          next_state = ST_HOLD; // R19
        end else if (clk_done) begin
          next_state   = ST_RUN;
          next_restart = !waking; // R20
          next_waking  = 1'b0;
        end
      end
      ST_RUN: begin
        if (any_req) begin
          next_state = ST_HOLD; // R12 R15
        end else if (i_power_down) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_req) begin
          next_state = ST_HOLD;
        end else if (i_wake) begin
          if (clk_wake_n == '0) begin
            next_state = ST_RUN; // R08
          end else begin
            clk_load    = 1'b1; // R08
            clk_val     = clk_load_of(clk_wake_n);
            next_waking = 1'b1;
            next_state  = ST_CLK;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state           <= ST_HOLD;
      waking          <= 1'b0;
      o_fetch_restart <= 1'b0;
    end else begin
      state           <= next_state;
      waking          <= next_waking;
      o_fetch_restart <= next_restart;
    end
  end

  // Request terms make reset take hold in the same cycle
  assign o_core_reset = any_req || (state == ST_HOLD) ||
                        (state == ST_WDT) ||
                        ((state == ST_CLK) && !waking); // R01 R12 R19
  assign o_core_stall = (state == ST_SLEEP) ||
                        ((state == ST_CLK) && waking);
  assign o_io_init    = o_core_reset; // R20
  assign o_start_addr = RESET_VECTOR; // R20

  assign o_brownout_enable     = fuse[FB_BOD_EN];
  assign o_brownout_level_high = fuse[FB_BODLVL]; // R16

endmodule
`default_nettype wire

//--- verif/sdr_seq_checker.sv
// Port-level assertions for the start-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
module sdr_seq_checker
  import sdr_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_nrst,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic              i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic              o_pready,
  input wire logic              o_pslverr,
  input wire logic              i_supply_ok,
  input wire logic              i_ext_reset_n,
  input wire logic              i_brownout_low,
  input wire logic              o_core_reset,
  input wire logic              o_io_init,
  input wire logic              o_fetch_restart,
  input wire logic [PC_W-1:0]   o_start_addr,
  input wire logic              o_brownout_enable,
  input wire logic              o_brownout_level_high
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // Consecutive cycles of low supply seen by the detector
  logic [11:0] bod_cnt;
  logic [11:0] next_bod_cnt;
  always_comb begin
    next_bod_cnt = 12'h000;
    if (i_brownout_low) begin
      next_bod_cnt = (bod_cnt == 12'hFFF) ? bod_cnt : bod_cnt + 12'h001;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bod_cnt <= 12'h000;
    end else begin
      bod_cnt <= next_bod_cnt;
    end
  end

  a_por_immediate: assert property (!i_supply_ok |-> o_core_reset)
    else $error("core out of reset while supply low");
  a_pin_filter: assert property (!i_ext_reset_n [*6] |-> o_core_reset)
    else $error("long pin pulse did not reset core");
  a_bod_trip_lo: assert property (o_brownout_enable &&
    bod_cnt >= 12'h965 |-> o_core_reset)
    else $error("long dip at low level did not reset");
  a_bod_trip_hi: assert property (o_brownout_enable &&
    o_brownout_level_high && bod_cnt >= 12'h2C1 |-> o_core_reset)
    else $error("long dip at high level did not reset");
  a_io_init: assert property (o_io_init == o_core_reset)
    else $error("io init differs from core reset");
  a_fetch_pulse: assert property ($fell(o_core_reset) |-> ##[0:1]
    o_fetch_restart ##1 !o_fetch_restart)
    else $error("no single fetch restart pulse");
  a_fetch_addr: assert property (o_fetch_restart |->
    !o_core_reset && o_start_addr == 10'h000)
    else $error("fetch restart with bad start");
  a_release_clear: assert property ($fell(o_core_reset) |->
    $past(i_supply_ok, 2) && $past(i_ext_reset_n, 2))
    else $error("core released with a request active");
  a_apb_ready: assert property (o_pready == (i_psel && i_penable))
    else $error("ready not in access cycle");
  a_apb_err: assert property (i_psel && i_penable &&
    (i_paddr[1:0] != 2'h0 || i_paddr > 8'h0C ||
    (i_pwrite && i_paddr != 8'h00)) |-> o_pslverr)
    else $error("bad access not refused");
endmodule

bind sdr_reset_sequencer sdr_seq_checker u_chk (
  .i_sys_clk            (i_sys_clk),
  .i_nrst               (i_nrst),
  .i_psel               (i_psel),
  .i_penable            (i_penable),
  .i_pwrite             (i_pwrite),
  .i_paddr              (i_paddr),
  .o_pready             (o_pready),
  .o_pslverr            (o_pslverr),
  .i_supply_ok          (i_supply_ok),
  .i_ext_reset_n        (i_ext_reset_n),
  .i_brownout_low       (i_brownout_low),
  .o_core_reset         (o_core_reset),
  .o_io_init            (o_io_init),
  .o_fetch_restart      (o_fetch_restart),
  .o_start_addr         (o_start_addr),
  .o_brownout_enable    (o_brownout_enable),
  .o_brownout_level_high(o_brownout_level_high)
);
`default_nettype wire

//--- verif/sdr_supply_model.sv
// Behavioural supply, reset pin and watchdog oscillator model
`timescale 1ns/1ps
`default_nettype none
module sdr_supply_model #(
  parameter int TICK_DIV = 2
) (
  input  wire logic i_sys_clk,
  output logic      o_supply_ok,
  output logic      o_ext_reset_n,
  output logic      o_brownout_low,
  output logic      o_wdog_osc_tick
);
  int div;
  initial begin
    o_supply_ok = 1'b0;
    o_ext_reset_n = 1'b1;
    o_brownout_low = 1'b0;
    o_wdog_osc_tick = 1'b0;
    div = 0;
  end
  // Free-running oscillator, one pulse per period
  always @(posedge i_sys_clk) begin
    div <= (div == TICK_DIV - 1) ? 0 : div + 1;
    o_wdog_osc_tick <= (div == TICK_DIV - 1);
  end
  task automatic set_supply(input logic v);
    o_supply_ok <= v;
  endtask
  task automatic set_dip(input logic v);
    o_brownout_low <= v;
  endtask
  // Pin pulled up when released; never shorter than the pulse filter
  task automatic pin_low(input int n);
    o_ext_reset_n <= 1'b0;
    repeat ((n < 6) ? 6 : n) @(posedge i_sys_clk);
    o_ext_reset_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- verif/test_sdr_reset_sequencer.sv
// Self-checking bench for the start-up reset sequencer
`timescale 1ns/1ps
`default_nettype none
module test_sdr_reset_sequencer
  import sdr_pkg::*;
;
  logic        clk, nrst, psel, penable, pwrite, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, supply_ok, ext_n, dip, tick;
  logic        power_down, wake, core_reset, stall, io_init, fetch;
  logic        brown_en, brown_hi;
  logic [9:0]  start_addr;
  int          n_mismatch, cmp_count, cyc;
  localparam int NT = 20;
  // Fuse setting, watchdog ticks, clock cycles; 100 is the resonator
  logic [11:0] t_fuse [NT] = '{12'h08F, 12'h08E, 12'h0AE, 12'h08D,
    12'h0AD, 12'h08A, 12'h089, 12'h088, 12'h087, 12'h082, 12'h0A2,
    12'h080, 12'h081, 12'h010, 12'h100, 12'h200, 12'h310, 12'h400,
    12'h500, 12'h510};
  logic [20:0] t_wdt [NT] = '{21'h0, 21'h100, 21'h400, 21'h1000,
    21'h4000, 21'h1000, 21'h1000, 21'h1000, 21'h0, 21'h1000, 21'h4000,
    21'h100, 21'h0, 21'h400, 21'h4000, 21'h100000, 21'h10, 21'h400,
    21'h400, 21'h0};
  logic [15:0] t_clk [NT] = '{16'h400, 16'h400, 16'h400, 16'h400,
    16'h400, 16'h4000, 16'h400, 16'h8000, 16'h6, 16'h6, 16'h6, 16'h6,
    16'h6, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h5};

  sdr_reset_sequencer dut (
    .i_sys_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_supply_ok(supply_ok), .i_ext_reset_n(ext_n),
    .i_brownout_low(dip), .i_wdog_osc_tick(tick),
    .i_power_down(power_down), .i_wake(wake), .o_core_reset(core_reset),
    .o_core_stall(stall), .o_io_init(io_init), .o_fetch_restart(fetch),
    .o_start_addr(start_addr), .o_brownout_enable(brown_en),
    .o_brownout_level_high(brown_hi));
  sdr_supply_model u_env (
    .i_sys_clk(clk), .o_supply_ok(supply_ok), .o_ext_reset_n(ext_n),
    .o_brownout_low(dip), .o_wdog_osc_tick(tick));

  task automatic report_and_stop;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Cycles until core reset (or stall) falls, checked against a window
  task automatic rel(input string nm, input int lo, input int hi,
                     input logic sel);
    int n;
    n = 0;
    while ((sel ? stall : core_reset) !== 1'b0 && n < hi + 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(nm, 32'h1, {31'h0, (n >= lo && n <= hi)});
  endtask
  task automatic pwr(input logic [11:0] f, input int lo, input int hi);
    apb(1'b1, OFF_FUSE, {20'h0, f});
    u_env.set_supply(1'b0);
    #1;
    chk("por assert", 32'h1, {31'h0, core_reset});
    @(posedge clk);
    u_env.set_supply(1'b1);
    rel("por release", lo, hi, 1'b0);
    chk("start addr", 32'h0, {22'h0, start_addr});
  endtask
  task automatic brownout_detector(input logic [11:0] f, input int ok_n, input int t_n);
    apb(1'b1, OFF_FUSE, {20'h0, f});
    u_env.set_dip(1'b1);
    #1;
    chk("level out", {31'h0, f[5]}, {31'h0, brown_hi});
    chk("enable out", {31'h0, f[6]}, {31'h0, brown_en});
    repeat (ok_n) @(posedge clk);
    #1;
    chk("dip ignored", 32'h0, {31'h0, core_reset});
    repeat (t_n) @(posedge clk);
    #1;
    chk("bod reset", 32'h1, {31'h0, core_reset});
    @(posedge clk);
    u_env.set_dip(1'b0);
    rel("bod release", 5, 12, 1'b0);
  endtask
  // Sleep, then wake under fuse f; wake count window lo..hi
  task automatic nap(input logic [11:0] f, input int lo, input int hi);
    apb(1'b1, OFF_FUSE, {20'h0, f});
    power_down <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("sleep stall", 32'h1, {31'h0, stall});
    @(posedge clk);
    wake <= 1'b1;
    power_down <= 1'b0;
    @(posedge clk);
    wake <= 1'b0;
    rel("wake count", lo, hi, 1'b1);
    chk("wake no reset", 32'h0, {31'h0, core_reset});
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    {nrst, psel, penable, pwrite, power_down, wake} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    {n_mismatch, cmp_count, cyc} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, OFF_FUSE, 32'h0);
    chk("fuse reset", FUSE_RESET, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, e});
    apb(1'b1, OFF_STATUS, 32'hFF);
    chk("ro write err", 32'h1, {31'h0, e});
    for (int i = 0; i < NT; i++) begin
      apb(1'b1, OFF_FUSE, {20'h0, t_fuse[i]});
      apb(1'b0, OFF_WDT_LOAD, 32'h0);
      chk("wdt count", {11'h0, t_wdt[i]}, q);
      apb(1'b0, OFF_CLK_LOAD, 32'h0);
      chk("clk count", {16'h0, t_clk[i]}, q);
    end
    pwr(12'h084, 5, 12);
    nap(12'h510, 1, 3);
    nap(12'h083, 4, 10);
    @(posedge clk);
    u_env.pin_low(20);
    rel("pin release", 510, 530, 1'b0);
    pwr(12'h083, 510, 530);
    pwr(12'h0A3, 2040, 2065);
    // Supply drop in mid-count restarts the whole delay
    @(posedge clk);
    u_env.set_supply(1'b0);
    @(posedge clk);
    u_env.set_supply(1'b1);
    repeat (300) @(posedge clk);
    u_env.set_supply(1'b0);
    @(posedge clk);
    u_env.set_supply(1'b1);
    rel("restart", 2040, 2065, 1'b0);
    brownout_detector(12'h0C4, 2300, 110);
    brownout_detector(12'h0E4, 680, 30);
    report_and_stop();
  end
endmodule
`default_nettype wire
